// ### design/wlb_pkg.sv
// Package for the word line buffer: frame layout, commands, status tests, bit timing.
// Assumes a 100 MHz mclk; the bit rate is chosen by a select input.
package wlb_pkg;
	localparam int unsigned DATA_BITS  = 20;
	localparam int unsigned FRAME_BITS = 22;
	localparam int unsigned CPU_BITS   = 18;
	localparam int unsigned CLK_HZ     = 100000000;
	// Selectable line rates in bits per second
	localparam int unsigned RATE_600   = 600;
	localparam int unsigned RATE_1200  = 1200;
	localparam int unsigned RATE_1800  = 1800;
	localparam int unsigned RATE_2000  = 2000;
	localparam int unsigned RATE_2400  = 2400;
	localparam int unsigned RATE_3000  = 3000;
	localparam int unsigned BIT_W      = 18;
	// External function commands
	localparam logic [3:0] CMD_CLR_RX = 4'h1;
	localparam logic [3:0] CMD_CLR_TX = 4'h2;
	localparam logic [3:0] CMD_RX_MODE = 4'h3;
	localparam logic [3:0] CMD_TX_MODE = 4'h4;
	// Status tests
	localparam logic [3:0] TEST_RX_FLAG = 4'h1;
	localparam logic [3:0] TEST_TX_FLAG = 4'h2;
	localparam logic MARK  = 1'b1;
	localparam logic SPACE = 1'b0;

	typedef enum logic [1:0]
	{
		WLB_RX_IDLE  = 2'b00,
		WLB_RX_START = 2'b01,
		WLB_RX_SHIFT = 2'b10
	} wlb_rx_state_t;

	// Cycles per bit for a rate select code, default is the slowest rate
	function automatic logic [BIT_W-1:0] wlb_bit_cycles(input logic [2:0] sel, input int unsigned clk_hz);
		int unsigned r;
		r = RATE_600;
		unique case (sel)
			3'h1: r = RATE_1200;
			3'h2: r = RATE_1800;
			3'h3: r = RATE_2000;
			3'h4: r = RATE_2400;
			3'h5: r = RATE_3000;
			default: r = RATE_600;
		endcase
		return BIT_W'(clk_hz / r);
	endfunction
endpackage

// ### design/wlb_tick_if.sv
// Interface carrying the bit-clock request and tick between the top and its timer.
// Assumes both ends run on mclk.
interface wlb_tick_if;
	import wlb_pkg::*;
	logic              run;
	logic              half;
	logic [BIT_W-1:0]  period;
	logic              tick;
	modport ctrl (output run, output half, output period, input tick);
	modport timer (input run, input half, input period, output tick);
endinterface

// ### design/wlb_bit_timer.sv
// Bit timer: while run is high, pulses tick after each bit period.
// With half set the first tick comes after half a period.
// Assumes run and period come from logic on mclk.
module wlb_bit_timer
	import wlb_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	wlb_tick_if.timer tk
);
	logic [BIT_W-1:0] count;
	logic [BIT_W-1:0] next_count;
	logic             tick_q;
	logic             next_tick;

	////////////////////////////////////////////////////////////////////////
	// Count down; restart from the full period after every tick
	always_comb
	begin
		next_count = count;
		next_tick  = 1'b0;
		if (!tk.run)
			next_count = tk.half ? (tk.period >> 1) : tk.period;
		else if (count <= BIT_W'(1))
		begin
			next_tick  = 1'b1;
			next_count = tk.period;
		end
		else
			next_count = count - BIT_W'(1);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			count  <= next_count;
			tick_q <= next_tick;
		end
	end

	assign tk.tick = tick_q;
endmodule

// ### design/word_line_buffer.sv
// Half-duplex word line buffer: 20-bit words framed by a start space and a stop mark.
// Assumes command, test and transfer strobes are one-cycle pulses from logic on mclk;
// the receive line comes from a pin and is synchronised here.
//
// Behaviour
// - Frames are one space start bit, twenty data bits, one mark stop; idle is mark.
// - Receive clock starts only after half a bit of steady space; shorter is noise.
// - Start bit shifts in, then the line is sampled once per bit period.
// - Full shift register copies twenty data bits, sets receive flag, stops clock.
// - Receive restarts on the next valid start bit.
// - New words overwrite the data register even while the receive flag is set.
// - Reading the received word clears the data register and receive flag.
// - Receive shift register holds the full 22-bit frame when a word completes.
// - Command 3 selects receive mode; command 1 clears receive flag and data.
// - Command 4 selects transmit mode and starts transmission.
// - When a word finishes, the waiting word loads and the transmit flag sets.
// - Transmitted frame is start bit, twenty bits, stop bit: 22 bits.
// - While transmit flag stays set, the line idles at mark until cleared.
// - Writing a new transmit word clears the transmit flag.
// - Transmit bits leave at regular intervals set by the line rate.
// - Read gives bits 18..1 to the processor, 19 and 20 to control flops.
// - Write takes bits 18..1 from processor, 19 from control bit, 20 parity.
// - Command 2 clears the transmit flag and transmit data register.
// - Status test 1 reports receive flag; test 2 reports transmit flag.
module word_line_buffer
	import wlb_pkg::*;
#(
	// Clock rate that the bit timing is derived from; a bench may scale it down
	parameter int unsigned CLK_RATE_HZ = CLK_HZ
)
(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic [2:0]          rate_sel,
	input  wire logic                line_rx,
	output logic                     line_tx,
	input  wire logic                cmd_valid,
	input  wire logic [3:0]          external_function_cmd,
	input  wire logic                test_valid,
	input  wire logic [3:0]          external_status_test,
	output logic                     test_result,
	input  wire logic                move_in,
	input  wire logic [CPU_BITS-1:0] move_in_data,
	input  wire logic                ctl_bit1_in,
	input  wire logic                move_out,
	output logic [CPU_BITS-1:0]      move_out_data,
	output logic                     ctl_bit1_out,
	output logic                     ctl_bit3_out,
	output logic                     rx_flag,
	output logic                     tx_flag,
	output logic                     tx_mode
);
	wlb_tick_if tk ();

	logic                  rx_s1, rx_s2;
	wlb_rx_state_t         rx_st, next_rx_st;
	logic [FRAME_BITS-1:0] rx_sr, next_rx_sr;
	logic [4:0]            rx_cnt, next_rx_cnt;
	logic [DATA_BITS-1:0]  rx_data, next_rx_data;
	logic                  next_rx_flag;
	logic [FRAME_BITS-1:0] tx_sr, next_tx_sr;
	logic [4:0]            tx_cnt, next_tx_cnt;
	logic [DATA_BITS-1:0]  tx_data, next_tx_data;
	logic                  next_tx_flag, next_tx_mode, next_line_tx;
	logic                  tx_busy, next_tx_busy;
	logic [CPU_BITS-1:0]   next_move_out_data;
	logic                  next_ctl1, next_ctl3, next_test;
	logic                  cmd_rx, cmd_tx;

	////////////////////////////////////////////////////////////////////////
	// Line synchroniser; only the second stage is read
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_s1 <= MARK;
			rx_s2 <= MARK;
		end
		else
		begin
			rx_s1 <= line_rx;
			rx_s2 <= rx_s1;
		end
	end

	assign cmd_rx = cmd_valid && external_function_cmd == CMD_RX_MODE;
	assign cmd_tx = cmd_valid && external_function_cmd == CMD_TX_MODE;

	// One timer is shared: the channel is half duplex, so only one direction runs
	assign tk.period = wlb_bit_cycles(rate_sel, CLK_RATE_HZ);
	assign tk.half   = !tx_mode && rx_st == WLB_RX_IDLE;
	assign tk.run    = tx_mode ? 1'b1 : (rx_st != WLB_RX_IDLE || rx_s2 == SPACE);

	wlb_bit_timer u_timer
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.tk    (tk)
	);

	////////////////////////////////////////////////////////////////////////
	// Receive: start qualification, sampling, transfer to data register
	always_comb
	begin
		next_rx_st   = rx_st;
		next_rx_sr   = rx_sr;
		next_rx_cnt  = rx_cnt;
		next_rx_data = rx_data;
		next_rx_flag = rx_flag;
		// Clear first so that a completing word in the same cycle wins
		if (move_out || (cmd_valid && external_function_cmd == CMD_CLR_RX))
		begin
			next_rx_flag = 1'b0;
			next_rx_data = '0;
		end
		if (tx_mode)
			next_rx_st = WLB_RX_IDLE;
		else
		begin
			unique case (rx_st)
				WLB_RX_IDLE:
					// Timer runs only while space persists; a short pulse reloads it
					if (tk.tick && rx_s2 == SPACE)
					begin
						next_rx_st  = WLB_RX_SHIFT;
						next_rx_sr  = {rx_sr[FRAME_BITS-2:0], rx_s2};
						next_rx_cnt = 5'h1;
					end
				WLB_RX_SHIFT:
					if (tk.tick)
					begin
						next_rx_sr  = {rx_sr[FRAME_BITS-2:0], rx_s2};
						next_rx_cnt = rx_cnt + 5'h1;
						if (rx_cnt == 5'(FRAME_BITS - 1))
						begin
							// Overwrites an untaken word on purpose
							next_rx_data = {rx_sr[DATA_BITS-1:0]};
							next_rx_flag = 1'b1;
							next_rx_st   = WLB_RX_IDLE;
						end
					end
				default: next_rx_st = WLB_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_st   <= WLB_RX_IDLE;
			rx_sr   <= '0;
			rx_cnt  <= '0;
			rx_data <= '0;
			rx_flag <= 1'b0;
		end
		else
		begin
			rx_st   <= next_rx_st;
			rx_sr   <= next_rx_sr;
			rx_cnt  <= next_rx_cnt;
			rx_data <= next_rx_data;
			rx_flag <= next_rx_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit: frame shifter, refill from data register, mark fill
	always_comb
	begin
		next_tx_sr   = tx_sr;
		next_tx_cnt  = tx_cnt;
		next_tx_data = tx_data;
		next_tx_flag = tx_flag;
		next_tx_mode = tx_mode;
		next_tx_busy = tx_busy;
		next_line_tx = line_tx;
		if (cmd_rx)
			next_tx_mode = 1'b0;
		if (cmd_tx)
			next_tx_mode = 1'b1;
		if (cmd_valid && external_function_cmd == CMD_CLR_TX)
		begin
			next_tx_flag = 1'b0;
			next_tx_data = '0;
		end
		if (move_in)
		begin
			// Bit 20 odd parity, bit 19 control bit, 18..1 processor
			next_tx_data = {~(^{ctl_bit1_in, move_in_data}), ctl_bit1_in, move_in_data};
			next_tx_flag = 1'b0;
		end
		if (!tx_mode)
		begin
			next_line_tx = MARK;
			next_tx_busy = 1'b0;
		end
		else if (tk.tick)
		begin
			if (tx_busy)
			begin
				next_line_tx = tx_sr[0];
				next_tx_sr   = {MARK, tx_sr[FRAME_BITS-1:1]};
				next_tx_cnt  = tx_cnt + 5'h1;
				if (tx_cnt == 5'(FRAME_BITS - 1))
					next_tx_busy = 1'b0;
			end
			else if (!tx_flag)
			begin
				// Frame shifts LSB first: start, data, stop
				next_tx_sr   = {MARK, tx_data, SPACE};
				next_tx_flag = 1'b1;
				next_tx_busy = 1'b1;
				next_tx_cnt  = '0;
				next_line_tx = MARK;
			end
			else
				next_line_tx = MARK;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sr   <= '1;
			tx_cnt  <= '0;
			tx_data <= '0;
			tx_flag <= 1'b0;
			tx_mode <= 1'b0;
			tx_busy <= 1'b0;
			line_tx <= MARK;
		end
		else
		begin
			tx_sr   <= next_tx_sr;
			tx_cnt  <= next_tx_cnt;
			tx_data <= next_tx_data;
			tx_flag <= next_tx_flag;
			tx_mode <= next_tx_mode;
			tx_busy <= next_tx_busy;
			line_tx <= next_line_tx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Processor read path and status tests
	always_comb
	begin
		next_move_out_data = move_out_data;
		next_ctl1          = ctl_bit1_out;
		next_ctl3          = ctl_bit3_out;
		next_test          = test_result;
		if (move_out)
		begin
			next_move_out_data = rx_data[CPU_BITS-1:0];
			next_ctl1          = rx_data[CPU_BITS];
			next_ctl3          = rx_data[CPU_BITS+1];
		end
		if (test_valid)
			next_test = (external_status_test == TEST_RX_FLAG && rx_flag)
				|| (external_status_test == TEST_TX_FLAG && tx_flag);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			move_out_data <= '0;
			ctl_bit1_out  <= 1'b0;
			ctl_bit3_out  <= 1'b0;
			test_result   <= 1'b0;
		end
		else
		begin
			move_out_data <= next_move_out_data;
			ctl_bit1_out  <= next_ctl1;
			ctl_bit3_out  <= next_ctl3;
			test_result   <= next_test;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_RX_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
		move_out && !(rx_st == WLB_RX_SHIFT && tk.tick && rx_cnt == 5'(FRAME_BITS-1)) |=> !rx_flag)
		else $error("receive flag not cleared by read");
	AST_RX_SET: assert property (@(posedge mclk) disable iff (!rst_n)
		!tx_mode && rx_st == WLB_RX_SHIFT && tk.tick && rx_cnt == 5'(FRAME_BITS-1) |=> rx_flag
		&& rx_st == WLB_RX_IDLE && rx_data == $past(rx_sr[DATA_BITS-1:0]))
		else $error("word completion did not set flag");
	AST_TX_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
		move_in && !(tx_mode && tk.tick && !tx_busy) |=> !tx_flag)
		else $error("write did not clear transmit flag");
	AST_TX_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
		tx_mode && !tx_busy && tx_flag && tk.tick |=> line_tx == MARK)
		else $error("line not marking while flag set");
	AST_TX_RX_MARK: assert property (@(posedge mclk) disable iff (!rst_n)
		!tx_mode |=> line_tx == MARK)
		else $error("line not mark outside transmit");
	AST_TX_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		tx_mode && tk.tick && !tx_busy && !tx_flag && !move_in |=> tx_flag && tx_busy && tx_sr[0] == SPACE)
		else $error("refill did not set flag");
	AST_CMD_TX: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_tx |=> tx_mode)
		else $error("transmit mode not entered");
	AST_CMD_RX: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_rx && !cmd_tx |=> !tx_mode)
		else $error("receive mode not entered");
	AST_PARITY: assert property (@(posedge mclk) disable iff (!rst_n)
		move_in |=> ^tx_data == 1'b1)
		else $error("transmit word parity not odd");
endmodule

// ### verification/wlb_remote.sv
// Far-end model: a remote word-serial station that sends and captures frames.
// Assumes the buffer runs at the 3000 bps select and shares mclk with this model.
module wlb_remote
	import wlb_pkg::*;
#(
	parameter int unsigned CLK_RATE_HZ = CLK_HZ
)
(
	input  wire logic mclk,
	input  wire logic line_tx,
	output logic      line_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned P = CLK_RATE_HZ / RATE_3000;

	// Idle line is continuous mark
	initial line_rx = MARK;

	task automatic idle(input int unsigned n);
		repeat (n) @(posedge mclk);
	endtask

	////////////////////////////////////////////////////////////////
	// Send start space, word bit 20 first, then stop mark
	task automatic send_word(input logic [DATA_BITS-1:0] w);
		logic [FRAME_BITS-1:0] f;
		f = {SPACE, w, MARK};
		for (int i = FRAME_BITS - 1; i >= 0; i--)
		begin
			line_rx <= f[i];
			idle(P);
		end
	endtask

	// Short space burst, to be ignored as noise
	task automatic glitch(input int unsigned n);
		line_rx <= SPACE;
		idle(n);
		line_rx <= MARK;
		idle(P);
	endtask

	////////////////////////////////////////////////////////////////
	// Capture one frame mid-bit, start bit lands in f[0]; bounded wait for start
	task automatic grab(output logic [FRAME_BITS-1:0] f, output logic ok);
		int unsigned n;
		n = 0;
		ok = 1'b0;
		f = '0;
		while (line_tx !== SPACE && n < 4 * P)
		begin
			@(posedge mclk);
			n++;
		end
		if (n < 4 * P)
		begin
			ok = 1'b1;
			idle(P / 2);
			for (int i = 0; i < FRAME_BITS; i++)
			begin
				f[i] = line_tx;
				if (i < FRAME_BITS - 1) idle(P);
			end
		end
	endtask
endmodule

// ### verification/test_word_line_buffer.sv
// Testbench for the word line buffer: commands, status tests, moves, and line frames.
// Assumes wlb_remote as the far-end station; runs at the fastest line rate to keep frames short.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
	$display("FAIL %s expected %h seen %h", nm, ex, got); end end
module test_word_line_buffer
	import wlb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Scaled timing base keeps a bit at 100 cycles so the whole run stays short
	localparam int unsigned TB_HZ = 300000;
	localparam int unsigned P = TB_HZ / RATE_3000;
	logic                  mclk = 1'b0;
	logic                  rst_n = 1'b1;
	logic                  line_rx, line_tx, test_result, rx_flag, tx_flag, tx_mode;
	logic                  cmd_valid = 1'b0;
	logic                  test_valid = 1'b0;
	logic                  move_in = 1'b0;
	logic                  move_out = 1'b0;
	logic                  ctl_bit1_in = 1'b0;
	logic                  ctl_bit1_out, ctl_bit3_out;
	logic [3:0]            external_function_cmd = 4'h0;
	logic [3:0]            external_status_test = 4'h0;
	logic [CPU_BITS-1:0]   move_in_data = '0;
	logic [CPU_BITS-1:0]   move_out_data;
	logic [FRAME_BITS-1:0] frame;
	logic                  ok;
	int                    bad_count = 0;
	int                    n_tests = 0;

	// 100 MHz clock
	always #5 mclk = ~mclk;

	word_line_buffer #(.CLK_RATE_HZ(TB_HZ)) u_word_line_buffer (.mclk(mclk), .rst_n(rst_n), .rate_sel(3'h5),
		.line_rx(line_rx),
		.line_tx(line_tx), .cmd_valid(cmd_valid), .external_function_cmd(external_function_cmd),
		.test_valid(test_valid), .external_status_test(external_status_test), .test_result(test_result),
		.move_in(move_in), .move_in_data(move_in_data), .ctl_bit1_in(ctl_bit1_in), .move_out(move_out),
		.move_out_data(move_out_data), .ctl_bit1_out(ctl_bit1_out), .ctl_bit3_out(ctl_bit3_out),
		.rx_flag(rx_flag), .tx_flag(tx_flag), .tx_mode(tx_mode));
	wlb_remote #(.CLK_RATE_HZ(TB_HZ)) u_wlb_remote (.mclk(mclk), .line_tx(line_tx), .line_rx(line_rx));

	////////////////////////////////////////////////////////////////
	// Access tasks: one-cycle strobe, then let the registered answer settle
	task automatic settle();
		@(posedge mclk);
		cmd_valid <= 1'b0;
		test_valid <= 1'b0;
		move_in <= 1'b0;
		move_out <= 1'b0;
		@(posedge mclk);
		#1;
	endtask

	task automatic do_cmd(input logic [3:0] c);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		external_function_cmd <= c;
		settle();
	endtask

	task automatic do_test(input logic [3:0] c, input logic ex);
		@(posedge mclk);
		test_valid <= 1'b1;
		external_status_test <= c;
		settle();
		`CHK("test_result", ex, test_result)
	endtask

	task automatic do_read(input logic [DATA_BITS-1:0] ex);
		@(posedge mclk);
		move_out <= 1'b1;
		settle();
		`CHK("read word", ex, {ctl_bit3_out, ctl_bit1_out, move_out_data})
	endtask

	task automatic do_write(input logic [CPU_BITS-1:0] d, input logic c);
		@(posedge mclk);
		move_in <= 1'b1;
		move_in_data <= d;
		ctl_bit1_in <= c;
		settle();
	endtask

	task automatic end_test(input string nm);
		$display("test %s finished, %0d compares, %0d mismatches", nm, n_tests, bad_count);
	endtask

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Hang guard well beyond the longest expected run
	initial
	begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		// Falling edge at time zero, after the initial high, so the asynchronous reset is seen
		rst_n <= 1'b0;
		repeat (16) @(posedge mclk);
		`CHK("reset line", MARK, line_tx)
		`CHK("reset flags", 3'b000, {rx_flag, tx_flag, tx_mode})
		rst_n <= 1'b1;
		do_cmd(CMD_RX_MODE);
		do_cmd(CMD_CLR_RX);
		do_test(TEST_RX_FLAG, 1'b0);
		end_test("reset and receive mode");

		// Noise shorter than half a bit must not start a frame or shift alignment
		u_wlb_remote.glitch(P / 2 - 10);
		`CHK("noise flag", 1'b0, rx_flag)
		u_wlb_remote.send_word(20'hA5C3F);
		repeat (4) @(posedge mclk);
		`CHK("rx flag", 1'b1, rx_flag)
		do_test(TEST_RX_FLAG, 1'b1);
		// Second word arrives unread and must overwrite the first
		u_wlb_remote.send_word(20'h5A3C1);
		repeat (4) @(posedge mclk);
		do_read(20'h5A3C1);
		`CHK("rx flag after read", 1'b0, rx_flag)
		do_read(20'h00000);
		end_test("receive");

		// Transmit: write clears flag, mode command starts, frame checked on the wire
		do_write(18'h2A5C3, 1'b1);
		`CHK("tx flag after write", 1'b0, tx_flag)
		do_cmd(CMD_TX_MODE);
		`CHK("tx mode", 1'b1, tx_mode)
		u_wlb_remote.grab(frame, ok);
		`CHK("start seen", 1'b1, ok)
		`CHK("tx frame", {MARK, ~^{1'b1, 18'h2A5C3}, 1'b1, 18'h2A5C3, SPACE}, frame)
		`CHK("tx flag set", 1'b1, tx_flag)
		do_test(TEST_TX_FLAG, 1'b1);
		repeat (2 * P) @(posedge mclk);
		`CHK("idle mark", MARK, line_tx)
		do_cmd(CMD_CLR_TX);
		`CHK("tx flag cleared", 1'b0, tx_flag)
		do_cmd(CMD_RX_MODE);
		`CHK("rx mode", 1'b0, tx_mode)
		end_test("transmit");
		print_verdict();
	end
endmodule
